// ### hdl/ricf_front_end.sv
// Identity code, check generator and command gate of the single-wire token
//
// What this block does
// - Holds a fixed 64-bit identity: family, serial number, check byte.
// - Family field sits in the lowest eight bits and is sent first.
// - Serial number of exactly 48 bits follows the family field.
// - Top eight bits are a check value over the lower 56 bits.
// - Check value comes from an 8-bit shift register for x^8+x^5+x^4+1.
// - Check register starts cleared to zero.
// - Bits enter one per step, family low bit first, then serial.
// - After the 48th serial bit the register equals the stored check.
// - Overdrive command byte at standard speed switches to high speed.
// - Memory commands pass only after a ROM-level command succeeded.
// - Every byte goes least significant bit first.
// - Standard rate about 16.3 kbit/s, high speed up to 142 kbit/s.
`timescale 1ns/1ns
module ricf_front_end #(
   // Arbitrary neutral identity values
   parameter logic [ricf_pkg::FAMILY_W-1:0] FAMILY_CODE = 8'h5a,
   parameter logic [ricf_pkg::SERIAL_W-1:0] SERIAL_NUM  = 48'h0123_4567_89ab,
   // ROM-level command codes
   parameter logic [7:0] CMD_READ     = 8'h33,
   parameter logic [7:0] CMD_MATCH    = 8'h55,
   parameter logic [7:0] CMD_SEARCH   = 8'hf0,
   parameter logic [7:0] CMD_SKIP     = 8'hcc,
   parameter logic [7:0] CMD_OD_SKIP  = 8'h3c,
   parameter logic [7:0] CMD_OD_MATCH = 8'h69
) (
   // Clock and reset
   input  wire  logic                            clk_sys,
   input  wire  logic                            rst_b,
   // Bit layer of the link
   input  wire  ricf_pkg::ricf_reset_s           linkReset,
   input  wire  ricf_pkg::ricf_bit_s             rxBit,
   input  wire  logic                            txReq,
   output ricf_pkg::ricf_bit_s                   txBit,
   output logic [ricf_pkg::SLOT_W-1:0]           bitCycles,
   // Memory function side
   output ricf_pkg::ricf_byte_s                  memByte,
   // Identity and status
   output logic [ricf_pkg::ID_W-1:0]             romCode,
   output ricf_pkg::ricf_status_s                status
);
   import ricf_pkg::*;

   logic [1:0]        rstSync_ff;
   logic              rstSyncB;
   ricf_state_s       cur_ff;
   ricf_state_s       nxt_cur;
   logic [DATA_W-1:0] idData;
   logic              idBit;
   logic [7:0]        rxByte;
   logic              lastBit;

   // Reset release through two stages
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         rstSync_ff <= 2'h0;
      end else begin
         rstSync_ff <= {rstSync_ff[0], 1'b1};
      end
   end
   assign rstSyncB = rstSync_ff[1];

   assign idData  = {SERIAL_NUM, FAMILY_CODE};
   assign romCode = {cur_ff.idCrc, idData};
   assign idBit   = romCode[cur_ff.cnt];
   assign rxByte  = {rxBit.data, cur_ff.shift[7:1]};
   assign lastBit = (cur_ff.cnt == ID_LAST);

   always_comb begin
      nxt_cur          = cur_ff;
      nxt_cur.tx.valid = 1'b0;
      nxt_cur.mem.stb  = 1'b0;
      case (cur_ff.st)
         ST_CALC: begin
            // Check byte built once after reset from the fixed fields
            nxt_cur.crc = crcStep(cur_ff.crc, idData[cur_ff.cnt]);
            nxt_cur.cnt = cur_ff.cnt + 1'b1;
            if (cur_ff.cnt == CALC_LAST) begin
               nxt_cur.idCrc   = crcStep(cur_ff.crc, idData[cur_ff.cnt]);
               nxt_cur.idReady = 1'b1;
               nxt_cur.cnt     = IDX_ZERO;
               nxt_cur.st      = ST_IDLE;
            end
         end
         ST_CMD: begin
            if (rxBit.valid) begin
               nxt_cur.shift  = rxByte;
               nxt_cur.bitCnt = cur_ff.bitCnt + 1'b1;
               if (cur_ff.bitCnt == BYTE_LAST) begin
                  nxt_cur.bitCnt = BIT_ZERO;
                  nxt_cur.cnt    = IDX_ZERO;
                  nxt_cur.phase  = PH_TRUE;
                  case (rxByte)
                     CMD_READ: begin
                        nxt_cur.st = ST_READ;
                     end
                     CMD_MATCH: begin
                        nxt_cur.st = ST_MATCH;
                     end
                     CMD_SEARCH: begin
                        nxt_cur.st = ST_SEARCH;
                     end
                     CMD_SKIP: begin
                        nxt_cur.st        = ST_MEM;
                        nxt_cur.memAccess = 1'b1;
                     end
                     CMD_OD_SKIP: begin
                        nxt_cur.overdrive = 1'b1;
                        nxt_cur.st        = ST_MEM;
                        nxt_cur.memAccess = 1'b1;
                     end
                     CMD_OD_MATCH: begin
                        nxt_cur.overdrive = 1'b1;
                        nxt_cur.st        = ST_MATCH;
                     end
                     default: begin
                        nxt_cur.st = ST_IDLE;
                     end
                  endcase
               end
            end
            if (txReq) begin
               nxt_cur.tx = '{valid: 1'b1, data: 1'b1};
            end
         end
         ST_READ: begin
            if (txReq) begin
               nxt_cur.tx  = '{valid: 1'b1, data: idBit};
               nxt_cur.cnt = cur_ff.cnt + 1'b1;
               if (lastBit) begin
                  nxt_cur.st        = ST_MEM;
                  nxt_cur.memAccess = 1'b1;
               end
            end
         end
         ST_MATCH: begin
            if (rxBit.valid) begin
               nxt_cur.cnt = cur_ff.cnt + 1'b1;
               if (rxBit.data != idBit) begin
                  nxt_cur.st = ST_IDLE;
               end else if (lastBit) begin
                  nxt_cur.st        = ST_MEM;
                  nxt_cur.memAccess = 1'b1;
               end
            end
            if (txReq) begin
               nxt_cur.tx = '{valid: 1'b1, data: 1'b1};
            end
         end
         ST_SEARCH: begin
            case (cur_ff.phase)
               PH_TRUE: begin
                  if (txReq) begin
                     nxt_cur.tx    = '{valid: 1'b1, data: idBit};
                     nxt_cur.phase = PH_COMP;
                  end
               end
               PH_COMP: begin
                  if (txReq) begin
                     nxt_cur.tx    = '{valid: 1'b1, data: ~idBit};
                     nxt_cur.phase = PH_PICK;
                  end
               end
               default: begin
                  // Master picks a direction; a device on the other branch drops out
                  if (rxBit.valid) begin
                     nxt_cur.phase = PH_TRUE;
                     nxt_cur.cnt   = cur_ff.cnt + 1'b1;
                     if (rxBit.data != idBit) begin
                        nxt_cur.st = ST_IDLE;
                     end else if (lastBit) begin
                        nxt_cur.st        = ST_MEM;
                        nxt_cur.memAccess = 1'b1;
                     end
                  end else if (txReq) begin
                     nxt_cur.tx = '{valid: 1'b1, data: 1'b1};
                  end
               end
            endcase
         end
         ST_MEM: begin
            // Bytes reach the memory functions only here
            if (rxBit.valid) begin
               nxt_cur.shift  = rxByte;
               nxt_cur.bitCnt = cur_ff.bitCnt + 1'b1;
               if (cur_ff.bitCnt == BYTE_LAST) begin
                  nxt_cur.bitCnt = BIT_ZERO;
                  nxt_cur.mem    = '{stb: 1'b1, data: rxByte};
               end
            end
         end
         default: begin
            // Idle: released line reads as one
            if (txReq) begin
               nxt_cur.tx = '{valid: 1'b1, data: 1'b1};
            end
         end
      endcase
      // Outside ST_CALC bus reset wins over the bit layer in the same cycle, except that a high-speed reset keeps that cycle's overdrive command
      if (cur_ff.st != ST_CALC && linkReset.busReset) begin
         nxt_cur.st        = ST_CMD;
         nxt_cur.cnt       = IDX_ZERO;
         nxt_cur.bitCnt    = BIT_ZERO;
         nxt_cur.phase     = PH_TRUE;
         nxt_cur.memAccess = 1'b0;
         nxt_cur.tx.valid  = 1'b0;
         nxt_cur.mem.stb   = 1'b0;
         if (linkReset.stdSpeed) begin
            nxt_cur.overdrive = 1'b0;
         end
      end
   end

   always_ff @(posedge clk_sys or negedge rstSyncB) begin
      if (!rstSyncB) begin
         cur_ff           <= '0;
         cur_ff.st        <= ST_CALC;
         cur_ff.crc       <= CRC_INIT;
         cur_ff.idCrc     <= CRC_INIT;
      end else begin
         cur_ff <= nxt_cur;
      end
   end

   assign txBit     = cur_ff.tx;
   assign memByte   = cur_ff.mem;
   assign status    = '{idReady:   cur_ff.idReady,
                        overdrive: cur_ff.overdrive,
                        memAccess: cur_ff.memAccess};
   assign bitCycles = cur_ff.overdrive ? OD_BIT_CYC : STD_BIT_CYC;
endmodule : ricf_front_end

// ### common/ricf_pkg.sv
// Shared constants, types and the check-register step for the identity front end
package ricf_pkg;
   // Identity code layout, low bits first on the wire
   localparam int FAMILY_W = 8;
   localparam int SERIAL_W = 48;
   localparam int CRC_W    = 8;
   localparam int DATA_W   = FAMILY_W + SERIAL_W;
   localparam int ID_W     = DATA_W + CRC_W;
   localparam int IDX_W    = 6;

   // Check register: right-shifting form of x^8 + x^5 + x^4 + 1
   localparam logic [CRC_W-1:0] CRC_POLY = 8'h8c;
   localparam logic [CRC_W-1:0] CRC_INIT = 8'h00;

   localparam logic [IDX_W-1:0] CALC_LAST = 6'h37;
   localparam logic [IDX_W-1:0] ID_LAST   = 6'h3f;
   localparam logic [IDX_W-1:0] IDX_ZERO  = 6'h00;
   localparam logic [2:0]       BYTE_LAST = 3'h7;
   localparam logic [2:0]       BIT_ZERO  = 3'h0;

   // Search walk phases per identity bit
   localparam logic [1:0] PH_TRUE = 2'h0;
   localparam logic [1:0] PH_COMP = 2'h1;
   localparam logic [1:0] PH_PICK = 2'h2;

   // Link rates and the derived bit period in system clocks
   localparam int CLK_HZ       = 25_000_000;
   localparam int STD_RATE_BPS = 16_300;
   localparam int OD_RATE_BPS  = 142_000;
   localparam int SLOT_W       = 11;
   localparam logic [SLOT_W-1:0] STD_BIT_CYC =
      SLOT_W'((CLK_HZ + STD_RATE_BPS - 1) / STD_RATE_BPS);
   localparam logic [SLOT_W-1:0] OD_BIT_CYC =
      SLOT_W'((CLK_HZ + OD_RATE_BPS - 1) / OD_RATE_BPS);

   typedef enum logic [2:0] {
      ST_CALC,
      ST_IDLE,
      ST_CMD,
      ST_READ,
      ST_MATCH,
      ST_SEARCH,
      ST_MEM
   } ricf_state_e;

   typedef struct packed {
      logic valid;
      logic data;
   } ricf_bit_s;

   typedef struct packed {
      logic busReset;
      logic stdSpeed;
   } ricf_reset_s;

   typedef struct packed {
      logic       stb;
      logic [7:0] data;
   } ricf_byte_s;

   typedef struct packed {
      logic idReady;
      logic overdrive;
      logic memAccess;
   } ricf_status_s;

   typedef struct packed {
      ricf_state_e      st;
      logic             overdrive;
      logic             memAccess;
      logic             idReady;
      logic [CRC_W-1:0] crc;
      logic [CRC_W-1:0] idCrc;
      logic [IDX_W-1:0] cnt;
      logic [2:0]       bitCnt;
      logic [1:0]       phase;
      logic [7:0]       shift;
      ricf_bit_s        tx;
      ricf_byte_s       mem;
   } ricf_state_s;

   function automatic logic [CRC_W-1:0] crcStep(input logic [CRC_W-1:0] crc,
                                               input logic             inBit);
      logic [CRC_W-1:0] nxt;
      nxt = crc >> 1;
      if (crc[0] ^ inBit) begin
         nxt = nxt ^ CRC_POLY;
      end
      return nxt;
   endfunction : crcStep
endpackage : ricf_pkg

// ### dv/ricf_master_model.sv
// Bus master model driving the bit layer of the front end
`timescale 1ns/1ns
module ricf_master_model (
   // Clock
   input  wire logic                 clk_sys,
   // Bit layer towards the device
   output ricf_pkg::ricf_reset_s     linkReset,
   output ricf_pkg::ricf_bit_s       rxBit,
   output logic                      txReq,
   input  wire ricf_pkg::ricf_bit_s  txBit
);
   import ricf_pkg::*;
   initial begin
      linkReset = '0;
      rxBit = '0;
      txReq = 1'b0;
   end
   task automatic busRst(input logic std);
      @(posedge clk_sys) #1 linkReset = '{busReset: 1'b1, stdSpeed: std};
      @(posedge clk_sys) #1 linkReset.busReset = 1'b0;
   endtask : busRst
   task automatic sendByte(input logic [7:0] b);
      for (int i = 0; i < 8; i++) begin
         @(posedge clk_sys) #1 rxBit = '{valid: 1'b1, data: b[i]};
         // Data line shows the inverse once the slot is over
         @(posedge clk_sys) #1 rxBit = '{valid: 1'b0, data: ~b[i]};
      end
   endtask : sendByte
   task automatic sendBit(input logic b);
      @(posedge clk_sys) #1 rxBit = '{valid: 1'b1, data: b};
      @(posedge clk_sys) #1 rxBit = '{valid: 1'b0, data: ~b};
   endtask : sendBit
   task automatic readBit(output logic v, output logic d);
      @(posedge clk_sys) #1 txReq = 1'b1;
      @(posedge clk_sys) #1 txReq = 1'b0;
      v = txBit.valid;
      d = txBit.data;
   endtask : readBit
endmodule : ricf_master_model

// ### dv/ricf_front_end_assertions.sv
// Concurrent checks on the ports of the identity front end
`timescale 1ns/1ns
module ricf_front_end_assertions #(
   parameter logic [ricf_pkg::FAMILY_W-1:0] FAMILY_CODE = 8'h5a,
   parameter logic [ricf_pkg::SERIAL_W-1:0] SERIAL_NUM  = 48'h0123_4567_89ab
) (
   // Clock and reset
   input wire logic                          clk_sys,
   input wire logic                          rst_b,
   // Observed ports
   input wire ricf_pkg::ricf_reset_s         linkReset,
   input wire ricf_pkg::ricf_bit_s           rxBit,
   input wire logic                          txReq,
   input wire ricf_pkg::ricf_bit_s           txBit,
   input wire logic [ricf_pkg::SLOT_W-1:0]   bitCycles,
   input wire ricf_pkg::ricf_byte_s          memByte,
   input wire logic [ricf_pkg::ID_W-1:0]     romCode,
   input wire ricf_pkg::ricf_status_s        status
);
   import ricf_pkg::*;
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rst_b);
   fam_field_a: assert property (romCode[7:0] == FAMILY_CODE)
      else $error("family field wrong");
   serial_field_a: assert property (romCode[55:8] == SERIAL_NUM)
      else $error("serial field wrong");
   id_hold_a: assert property (status.idReady |=> status.idReady && $stable(romCode))
      else $error("identity not steady");
   tx_answer_a: assert property (txBit.valid |-> $past(txReq))
      else $error("unrequested read bit");
   rate_sel_a: assert property (bitCycles == (status.overdrive ? 11'h0b1 : 11'h5fe))
      else $error("bit period wrong");
   mem_gate_a: assert property (memByte.stb |-> status.memAccess && $past(rxBit.valid))
      else $error("memory byte while locked");
   reset_lock_a: assert property (linkReset.busReset && status.idReady |=> !status.memAccess)
      else $error("memory open after reset");
   std_exit_a: assert property (linkReset.busReset && linkReset.stdSpeed && status.idReady
      |=> !status.overdrive)
      else $error("high speed kept");
   od_entry_a: assert property ($rose(status.overdrive) |-> $past(rxBit.valid))
      else $error("high speed without command");
   od_keep_a: assert property (linkReset.busReset && !linkReset.stdSpeed
      |=> $stable(status.overdrive))
      else $error("high speed lost");
endmodule : ricf_front_end_assertions
bind ricf_front_end ricf_front_end_assertions #(.FAMILY_CODE(FAMILY_CODE),
   .SERIAL_NUM(SERIAL_NUM)) chk (.clk_sys(clk_sys), .rst_b(rst_b), .linkReset(linkReset),
   .rxBit(rxBit), .txReq(txReq), .txBit(txBit), .bitCycles(bitCycles),
   .memByte(memByte), .romCode(romCode), .status(status));

// ### dv/ricf_front_end_bench.sv
// Self-checking bench for the identity front end
`timescale 1ns/1ns
module ricf_front_end_bench;
   import ricf_pkg::*;
   localparam logic [55:0] FIXED = {48'h0123_4567_89ab, 8'h5a};
   logic              clk_sys = 1'b0;
   logic              rst_b = 1'b0;
   ricf_reset_s       linkReset;
   ricf_bit_s         rxBit;
   ricf_bit_s         txBit;
   logic              txReq;
   logic [SLOT_W-1:0] bitCycles;
   ricf_byte_s        memByte;
   logic [ID_W-1:0]   romCode;
   ricf_status_s      status;
   logic [63:0]       rd;
   logic              v;
   logic              d;
   int errors = 0;
   int n_compared = 0;
   int cycles = 0;
   always #20 clk_sys = ~clk_sys;
   ricf_front_end DUT (.clk_sys(clk_sys), .rst_b(rst_b), .linkReset(linkReset),
      .rxBit(rxBit), .txReq(txReq), .txBit(txBit), .bitCycles(bitCycles),
      .memByte(memByte), .romCode(romCode), .status(status));
   ricf_master_model m (.clk_sys(clk_sys), .linkReset(linkReset), .rxBit(rxBit),
      .txReq(txReq), .txBit(txBit));
   task automatic chk(input logic [63:0] got, input logic [63:0] exp);
      n_compared++;
      if (got !== exp) begin
         errors++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   function automatic logic [7:0] crcOf(input logic [63:0] x, input int n);
      logic [7:0] c;
      c = 8'h00;
      for (int i = 0; i < n; i++) begin
         c = {1'b0, c[7:1]} ^ ((c[0] ^ x[i]) ? 8'h8c : 8'h00);
      end
      return c;
   endfunction : crcOf
   task automatic idCode();
      chk(romCode[55:0], FIXED);
      chk(romCode[63:56], crcOf({8'h00, FIXED}, 56));
      chk(crcOf(romCode, 64), 64'h0);
   endtask : idCode
   task automatic readRom();
      m.busRst(1'b1);
      m.sendByte(8'h33);
      for (int i = 0; i < 64; i++) begin
         m.readBit(v, d);
         rd[i] = d;
         chk(v, 1'b1);
      end
      chk(rd, {crcOf({8'h00, FIXED}, 56), FIXED});
      @(posedge clk_sys) #1;
      chk(status.memAccess, 1'b1);
   endtask : readRom
   task automatic searchRom();
      m.busRst(1'b1);
      m.sendByte(8'hf0);
      for (int i = 0; i < 64; i++) begin
         m.readBit(v, d);
         rd[i] = d;
         m.readBit(v, d);
         chk({v, d}, {1'b1, ~rd[i]});
         m.sendBit(rd[i]);
      end
      chk(rd, {crcOf({8'h00, FIXED}, 56), FIXED});
      chk(status.memAccess, 1'b1);
      m.busRst(1'b1);
      m.sendByte(8'h55);
      m.sendBit(~FIXED[0]);
      chk(status.memAccess, 1'b0);
      m.readBit(v, d);
      chk({v, d}, 2'b11);
   endtask : searchRom
   task automatic memGate();
      m.busRst(1'b1);
      m.sendByte(8'h0f);
      chk({status.memAccess, memByte.stb}, 2'b00);
      m.readBit(v, d);
      chk({v, d}, 2'b11);
      m.busRst(1'b1);
      m.sendByte(8'hcc);
      chk(status.memAccess, 1'b1);
      m.sendByte(8'h26);
      chk(memByte, {1'b1, 8'h26});
      m.readBit(v, d);
      chk(v, 1'b0);
   endtask : memGate
   task automatic overdrive();
      m.busRst(1'b1);
      m.sendByte(8'h3c);
      chk({status.overdrive, status.memAccess, bitCycles}, {2'b11, 11'h0b1});
      m.busRst(1'b0);
      chk({status.overdrive, status.memAccess}, 2'b10);
      m.sendByte(8'h69);
      for (int i = 0; i < 8; i++) m.sendByte(romCode[i*8+:8]);
      @(posedge clk_sys) #1;
      chk({status.overdrive, status.memAccess}, 2'b11);
      m.busRst(1'b1);
      chk({status.overdrive, status.memAccess, bitCycles}, {2'b00, 11'h5fe});
   endtask : overdrive
   task automatic report_and_stop();
      $display("compared %0d, errors %0d", n_compared, errors);
      if (errors == 0 && n_compared > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask : report_and_stop
   always @(posedge clk_sys) begin
      cycles++;
      if (cycles == 20000) begin
         errors++;
         report_and_stop();
      end
   end
   initial begin
      repeat (5) @(posedge clk_sys);
      #1 rst_b = 1'b1;
      repeat (100) if (status.idReady !== 1'b1) @(posedge clk_sys);
      #1 chk(status.idReady, 1'b1);
      idCode();
      readRom();
      searchRom();
      memGate();
      overdrive();
      report_and_stop();
   end
endmodule : ricf_front_end_bench
